//--- src/tfs_port.sv
// character strobe port between coupler and tape formatter
// assumes strobes arrive asynchronous, active high after the line receivers
`timescale 1ns/1ps
`default_nettype none
`include "tfs_defs.svh"
module tfs_port
  import tfs_pkg::*;
(
  input wire logic clk_i, // 40 MHz core clock
  input wire logic rst_i, // async reset, active high
  input wire logic [1:0] mode_i, // tfs_mode_t, steady while busy
  input wire logic data_busy_flag_i, // formatter data busy
  input wire logic demand_write_strobe_i, // demand write pulse
  input wire logic read_strobe_i, // read strobe pulse
  input wire logic [7:0] read_char_lines_i, // read data, bit 7 is line 0
  input wire logic read_parity_line_i, // read parity
  input wire logic wr_valid_i, // write character offered
  output logic wr_ready_o, // write fifo has room
  input wire logic [8:0] wr_data_i, // {parity, data[7:0]}
  output logic [8:0] write_char_lines_o, // {parity, line7..line0}
  output logic wr_underrun_o, // demand found no character, sticky per busy
  output logic rd_valid_o, // read character available
  input wire logic rd_ready_i, // user takes read character
  output logic [8:0] rd_data_o, // {parity, data[7:0]}
  output logic rd_overrun_o, // strobe met full fifo, sticky per busy
  output logic [23:0] erase_count_o // demand pulses seen in erase
);
  tfs_mode_t mode;
  assign mode = tfs_mode_t'(mode_i);

  ////////////////////////////////////////////////////////////////
  // strobe synchronisers, first stage read only by second
  logic [1:0] dws_sync_q, rds_sync_q;
  logic dws_old_q, rds_old_q, busy_s1_q, busy_q, busy_old_q;
  logic [8:0] rd_hold1_q, rd_hold_q;
  logic dws_fall, rds_rise, busy_rise;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dws_sync_q <= 2'h0;
      rds_sync_q <= 2'h0;
      dws_old_q <= 1'b0;
      rds_old_q <= 1'b0;
      busy_s1_q <= 1'b0;
      busy_q <= 1'b0;
      busy_old_q <= 1'b0;
      rd_hold1_q <= 9'h000;
      rd_hold_q <= 9'h000;
    end else begin
      dws_sync_q <= {dws_sync_q[0], demand_write_strobe_i};
      rds_sync_q <= {rds_sync_q[0], read_strobe_i};
      dws_old_q <= dws_sync_q[1];
      rds_old_q <= rds_sync_q[1];
      busy_s1_q <= data_busy_flag_i;
      busy_q <= busy_s1_q;
      busy_old_q <= busy_q;
      // data is steady well before the strobe and 0.5 us after, so a
      // two-stage copy lines up with the synchronised strobe
      rd_hold1_q <= {read_parity_line_i, read_char_lines_i};
      rd_hold_q <= rd_hold1_q;
    end
  end

  // one pulse per strobe edge
  assign dws_fall = dws_old_q && !dws_sync_q[1];
  assign rds_rise = !rds_old_q && rds_sync_q[1];
  assign busy_rise = busy_q && !busy_old_q;

  ////////////////////////////////////////////////////////////////
  // write path: fifo feeds the output register
  logic wf_valid, wf_pop;
  logic [8:0] wf_data;
  tfs_wr_state_t wst_q, wst_d;
  logic [8:0] wchar_q, wchar_d;
  logic under_q, under_d;
  logic wr_active;

  assign wr_active = (mode == TFS_MODE_WRITE);

  tfs_fifo #(.WIDTH(`TFS_CHAR_W), .DEPTH(`TFS_FIFO_DEPTH)) u_wr_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(wr_valid_i),
    .in_ready_o(wr_ready_o),
    .in_data_i(wr_data_i),
    .out_valid_o(wf_valid),
    .out_ready_i(wf_pop),
    .out_data_o(wf_data),
    .count_o()
  );

  // state walk: present first char, then reload after each trailing edge
  always_comb begin
    wst_d = wst_q;
    wchar_d = wchar_q;
    under_d = under_q;
    wf_pop = 1'b0;
    case (wst_q)
      TFS_IDLE: begin
        if (busy_rise) begin
          under_d = 1'b0;
        end
        // mark and erase never load characters
        if (busy_q && wr_active) begin
          wst_d = TFS_FIRST;
        end
      end
      TFS_FIRST: begin
        // first char goes out as soon as it exists, two cycles after busy
        if (wf_valid) begin
          wf_pop = 1'b1;
          wchar_d = {wf_data[8], bitrev8(wf_data[7:0])};
          wst_d = TFS_NEXT;
        end else if (dws_fall) begin
          under_d = 1'b1;
        end
        if (!busy_q) begin
          wst_d = TFS_DONE;
        end
      end
      TFS_NEXT: begin
        // char held until the trailing edge, then replaced next cycle
        if (dws_fall) begin
          if (wf_valid) begin
            wf_pop = 1'b1;
            wchar_d = {wf_data[8], bitrev8(wf_data[7:0])};
          end else begin
            under_d = 1'b1;
          end
        end
        if (!busy_q) begin
          wst_d = TFS_DONE;
        end
      end
      TFS_DONE: begin
        wst_d = TFS_IDLE;
      end
      default: begin
        wst_d = TFS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wst_q <= TFS_IDLE;
      wchar_q <= 9'h000;
      under_q <= 1'b0;
    end else begin
      wst_q <= wst_d;
      wchar_q <= wchar_d;
      under_q <= under_d;
    end
  end

  // line 0 carries the most significant data bit
  function automatic logic [7:0] bitrev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction : bitrev8

  assign write_char_lines_o = wchar_q;
  assign wr_underrun_o = under_q;

  ////////////////////////////////////////////////////////////////
  // erase length counter
  logic [23:0] ecnt_q, ecnt_d;

  always_comb begin
    ecnt_d = ecnt_q;
    if (busy_rise && mode == TFS_MODE_ERASE) begin
      // a demand edge in the clearing cycle must not be lost
      ecnt_d = dws_fall ? 24'h000001 : 24'h000000;
    end else if (dws_fall && busy_q && mode == TFS_MODE_ERASE) begin
      ecnt_d = ecnt_q + 24'h000001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ecnt_q <= 24'h000000;
    end else begin
      ecnt_q <= ecnt_d;
    end
  end

  assign erase_count_o = ecnt_q;

  ////////////////////////////////////////////////////////////////
  // read path: every strobe pushes while the fifo has room, no pause toward the formatter
  logic rf_ready;
  logic over_q, over_d;

  // eight words cover rate swings; a slow drain still overruns
  tfs_fifo #(.WIDTH(`TFS_CHAR_W), .DEPTH(`TFS_FIFO_DEPTH)) u_rd_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(rds_rise),
    .in_ready_o(rf_ready),
    .in_data_i(rd_hold_q),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .out_data_o(rd_data_o),
    .count_o()
  );

  // sense bytes and data share this path; rate does not matter
  always_comb begin
    over_d = over_q;
    if (busy_rise) begin
      over_d = 1'b0;
    end
    if (rds_rise && !rf_ready) begin
      over_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      over_q <= 1'b0;
    end else begin
      over_q <= over_d;
    end
  end

  assign rd_overrun_o = over_q;

  ////////////////////////////////////////////////////////////////
  // checks
  a_dws_once: assert property (@(posedge clk_i) disable iff (rst_i)
    dws_fall |=> !dws_fall) else $error("demand edge seen twice");
  a_rds_push: assert property (@(posedge clk_i) disable iff (rst_i)
    rds_rise && rf_ready |=> rd_valid_o) else $error("read char not captured");
  a_next_char: assert property (@(posedge clk_i) disable iff (rst_i)
    wst_q == TFS_NEXT && dws_fall && wf_valid |=> write_char_lines_o == $past(
    {wf_data[8], bitrev8(wf_data[7:0])})) else $error("next char late");
  a_first_char: assert property (@(posedge clk_i) disable iff (rst_i)
    wst_q == TFS_FIRST && wf_valid |=> wst_q == TFS_NEXT || wst_q == TFS_DONE)
    else $error("first char not loaded");
  a_mark_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    mode != TFS_MODE_WRITE && wst_q == TFS_IDLE |=> wst_q == TFS_IDLE)
    else $error("mark or erase loaded chars");
  a_erase_count: assert property (@(posedge clk_i) disable iff (rst_i)
    dws_fall && busy_q && !busy_rise && mode == TFS_MODE_ERASE |=> erase_count_o == $past(erase_count_o) + 24'h000001)
    else $error("erase pulse not counted");
  a_hold_char: assert property (@(posedge clk_i) disable iff (rst_i)
    wst_q == TFS_NEXT && !dws_fall |=> $stable(write_char_lines_o))
    else $error("char changed before demand edge");
  a_overrun: assert property (@(posedge clk_i) disable iff (rst_i)
    rds_rise && !rf_ready |=> rd_overrun_o) else $error("overrun not flagged");
  c_write: cover property (@(posedge clk_i) wst_q == TFS_NEXT && dws_fall);
  c_read: cover property (@(posedge clk_i) rds_rise);
  c_erase: cover property (@(posedge clk_i) mode == TFS_MODE_ERASE && dws_fall);
endmodule : tfs_port
`default_nettype wire

//--- src/tfs_defs.svh
// constants for the tape formatter data strobe port
// assumes a 40 MHz core clock
`ifndef TFS_DEFS_SVH
`define TFS_DEFS_SVH
`define TFS_CLK_MHZ 40
`define TFS_CHAR_W 9
`define TFS_FIFO_DEPTH 8
`define TFS_WR_PULSE_NS 1000
`define TFS_RD_PULSE_NS 1200
`define TFS_RD_HOLD_NS 500
`define TFS_WR_PULSE_CYC ((`TFS_WR_PULSE_NS * `TFS_CLK_MHZ) / 1000)
`define TFS_RD_PULSE_CYC ((`TFS_RD_PULSE_NS * `TFS_CLK_MHZ) / 1000)
`define TFS_ERASE_CNT_W 24
`define TFS_MODE_W 2
`endif

//--- src/tfs_pkg.sv
// types for the tape formatter data strobe port
// assumes tfs_defs.svh holds the numbers
package tfs_pkg;
  typedef enum logic [3:0] {
    TFS_IDLE = 4'h1,
    TFS_FIRST = 4'h2,
    TFS_NEXT = 4'h4,
    TFS_DONE = 4'h8
  } tfs_wr_state_t;
  typedef enum logic [1:0] {
    TFS_MODE_READ = 2'h0,
    TFS_MODE_WRITE = 2'h1,
    TFS_MODE_MARK = 2'h2,
    TFS_MODE_ERASE = 2'h3
  } tfs_mode_t;
endpackage : tfs_pkg

//--- src/tfs_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock, asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module tfs_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // async reset
  input wire logic in_valid_i, // write side valid
  output logic in_ready_o, // not full
  input wire logic [WIDTH-1:0] in_data_i, // write data
  output logic out_valid_o, // not empty
  input wire logic out_ready_i, // read side ready
  output logic [WIDTH-1:0] out_data_o, // head word
  output logic [$clog2(DEPTH):0] count_o // fill level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  ////////////////////////////////////////////////////////////////
  // pointer and count update
  always_comb begin
    push = in_valid_i && (cnt_q != DEPTH[AW:0]);
    pop = out_valid_o && out_ready_i;
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset; only words behind the count are read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rp_q];
  assign count_o = cnt_q;
endmodule : tfs_fifo
`default_nettype wire

//--- test/tfs_fmt_model.sv
// formatter side model: data busy, demand pulses, read strobes with data
// assumes a 40 MHz clock paces every edge it makes
`timescale 1ns/1ps
`default_nettype none
`include "tfs_defs.svh"
module tfs_fmt_model (
  input wire logic clk_i, // core clock, pacing only
  output logic data_busy_o, // data busy level
  output logic demand_o, // demand write pulse
  output logic strobe_o, // read strobe pulse
  output logic [7:0] rd_lines_o, // read data lines
  output logic rd_par_o // read parity line
);
  ////////////////////////////////////////
  // idle levels at time zero
  initial begin
    data_busy_o = 1'b0;
    demand_o = 1'b0;
    strobe_o = 1'b0;
    rd_lines_o = 8'h5A;
    rd_par_o = 1'b0;
  end

  // busy only moves when the bench says the tape is at speed
  task automatic busy(input logic b);
    @(posedge clk_i);
    data_busy_o <= b;
  endtask : busy

  // one pulse of the write demand, then a quiet gap
  task automatic demand(input int gap);
    @(posedge clk_i);
    demand_o <= 1'b1;
    repeat (`TFS_WR_PULSE_CYC) @(posedge clk_i);
    demand_o <= 1'b0;
    repeat (gap) @(posedge clk_i);
  endtask : demand

  // data leads the strobe, holds past it, then turns to garbage
  task automatic strobe(input logic [8:0] ch, input int gap);
    @(posedge clk_i);
    {rd_par_o, rd_lines_o} <= ch;
    @(posedge clk_i);
    strobe_o <= 1'b1;
    repeat (`TFS_RD_PULSE_CYC) @(posedge clk_i);
    strobe_o <= 1'b0;
    repeat ((`TFS_RD_HOLD_NS * `TFS_CLK_MHZ) / 1000) @(posedge clk_i);
    {rd_par_o, rd_lines_o} <= ~ch; // held time over, lines no longer valid
    repeat (gap) @(posedge clk_i);
  endtask : strobe
endmodule : tfs_fmt_model
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the tape formatter strobe port
// assumes tfs_fmt_model stands on the formatter side
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tfs_pkg::*;
;
  logic clk_i;
  logic rst_i;
  logic [1:0] mode;
  logic wr_valid;
  logic rd_ready;
  logic [8:0] wr_data;
  logic busy, dws, rstr, rpar, wr_ready, underrun, rd_valid, overrun;
  logic [7:0] rd_lines;
  logic [8:0] wlines, rd_data;
  logic [23:0] ecount;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;

  ////////////////////////////////////////
  // 25 ns clock
  always #12.5 clk_i = ~clk_i;

  tfs_port i_tfs_port (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode), .data_busy_flag_i(busy),
    .demand_write_strobe_i(dws), .read_strobe_i(rstr), .read_char_lines_i(rd_lines),
    .read_parity_line_i(rpar), .wr_valid_i(wr_valid), .wr_ready_o(wr_ready), .wr_data_i(wr_data),
    .write_char_lines_o(wlines), .wr_underrun_o(underrun), .rd_valid_o(rd_valid),
    .rd_ready_i(rd_ready), .rd_data_o(rd_data), .rd_overrun_o(overrun), .erase_count_o(ecount));
  tfs_fmt_model i_tfs_fmt_model (.clk_i(clk_i), .data_busy_o(busy), .demand_o(dws),
    .strobe_o(rstr), .rd_lines_o(rd_lines), .rd_par_o(rpar));

  ////////////////////////////////////////
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // a hang counts as a mismatch
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // line 0 carries the top bit, so the byte goes out reversed
  function automatic logic [8:0] wexp(input logic [8:0] d);
    wexp[8] = d[8];
    for (int i = 0; i < 8; i++) wexp[i] = d[7 - i];
  endfunction : wexp

  function automatic logic [8:0] rch(input int i);
    rch = 9'h0A5 + 9'(i) * 9'h047;
  endfunction : rch

  task automatic wait_lines(input logic [8:0] exp, input int lim);
    for (int i = 0; i < lim && wlines !== exp; i++) @(posedge clk_i);
    chk("write lines", {15'h0000, exp}, {15'h0000, wlines});
  endtask : wait_lines

  // holds valid until taken; the caller drops it after the last word
  task automatic push(input logic [8:0] d);
    wr_valid <= 1'b1;
    wr_data <= d;
    do @(posedge clk_i); while (wr_ready !== 1'b1);
  endtask : push

  task automatic pop(output logic [8:0] d);
    for (int n = 0; n < 20 && rd_valid !== 1'b1; n++) @(posedge clk_i);
    d = rd_data;
    rd_ready <= 1'b1;
    @(posedge clk_i);
    rd_ready <= 1'b0;
    @(posedge clk_i);
  endtask : pop

  ////////////////////////////////////////
  task automatic test_write();
    logic [8:0] w [3] = '{9'h1A5, 9'h03C, 9'h181};
    @(posedge clk_i);
    mode <= TFS_MODE_WRITE;
    foreach (w[i]) push(w[i]);
    wr_valid <= 1'b0;
    i_tfs_fmt_model.busy(1'b1);
    wait_lines(wexp(w[0]), 200);
    for (int i = 1; i < 3; i++) begin
      i_tfs_fmt_model.demand(0);
      chk("held char", {15'h0000, wexp(w[i - 1])}, {15'h0000, wlines});
      wait_lines(wexp(w[i]), 100);
    end
    i_tfs_fmt_model.demand(10);
    chk("underrun", 24'h000001, {23'h000000, underrun});
    i_tfs_fmt_model.busy(1'b0);
    $display("test_write done");
  endtask : test_write

  // no demand pulses at all during a file mark
  task automatic test_mark();
    @(posedge clk_i);
    mode <= TFS_MODE_MARK;
    i_tfs_fmt_model.busy(1'b1);
    repeat (100) @(posedge clk_i);
    chk("mark underrun", 24'h000000, {23'h000000, underrun});
    i_tfs_fmt_model.busy(1'b0);
    $display("test_mark done");
  endtask : test_mark

  // second pass shows the count restarts at each busy rise
  task automatic test_erase();
    for (int r = 0; r < 2; r++) begin
      @(posedge clk_i);
      mode <= TFS_MODE_ERASE;
      i_tfs_fmt_model.busy(1'b1);
      repeat (5) i_tfs_fmt_model.demand(20);
      chk("erase count", 24'h000005, ecount);
      i_tfs_fmt_model.busy(1'b0);
    end
    $display("test_erase done");
  endtask : test_erase

  // nine strobes at twice then half the nominal rate, nothing popped
  task automatic test_read();
    logic [8:0] c;
    @(posedge clk_i);
    mode <= TFS_MODE_READ;
    i_tfs_fmt_model.busy(1'b1);
    for (int i = 0; i < 9; i++) i_tfs_fmt_model.strobe(rch(i), (i < 5) ? 31 : 331);
    chk("overrun", 24'h000001, {23'h000000, overrun});
    for (int i = 0; i < 8; i++) begin
      pop(c);
      chk("read char", {15'h0000, rch(i)}, {15'h0000, c});
    end
    chk("drained", 24'h000000, {23'h000000, rd_valid});
    i_tfs_fmt_model.busy(1'b0);
    $display("test_read done");
  endtask : test_read

  // reset for five cycles, then the scenarios in turn
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    mode = 2'h0;
    wr_valid = 1'b0;
    rd_ready = 1'b0;
    wr_data = 9'h000;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    test_write();
    test_mark();
    test_erase();
    test_read();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
